// File: design/wwdt_top.sv
// windowed watchdog timer with an AHB-Lite register slave
// assumes one 50 MHz clock, synchronous reset, single word transfers
// assumes each register sits in its own word, byte address = index * 4
// assumes sys_reset_req is routed to the system reset, not to rst
//
// What this block does
// R1 - service is 0x55 then 0xAA to cause register
// R2 - any other value written forces reset
// R3 - missing service before timeout forces reset
// R4 - windowed service only in last quarter
// R5 - early service in window mode resets now
// R6 - clock select 1 bus clock, 0 1 kHz
// R7 - reset default enabled, 1 kHz, 2^10
// R8 - timeout select 0:0 disables watchdog
// R9 - 1 kHz overflows 2^5, 2^8, 2^10, no window
// R10 - bus overflows 2^13/16/18, windows 6144/49152/196608
// R11 - options one and select bits write once
// R12 - software writes configuration once at init
// R13 - valid service clears the counter
// R14 - watchdog reset sets watchdog flag
//
// usage notes
// - options one and the select bits of options two take one write after rst; plan it well
// - low bits of options two stay writable, the select bits do not
// - a second 0x55 keeps the sequence armed, so retries are harmless
// - an unarmed 0xAA is a legal code and does not fire
// - the window is only checked on the bus clock source
// - a fault clears the counter and the sequence, like a system reset
// - the cause flag is cleared only by rst, so software can read it
//
// hazards
// - the divider runs free; the first slow tick after a change of
//   source may come early by up to one slow period
// - a good pair and a timeout in one cycle: the pair wins
//
// Decided for this implementation: the AHB-Lite register port.
`include "wwdt_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module wwdt_top
    import wwdt_pkg::*;
#(
    parameter int unsigned CLK_HZ = `WWDT_CLK_HZ,
    parameter int unsigned SLOW_HZ = `WWDT_SLOW_HZ
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // system reset request
    output logic sys_reset_req
);

    localparam int unsigned SLOW_DIV = CLK_HZ / SLOW_HZ;

    // overflow count for a select and clock source
    function automatic logic [18:0] wwdt_limit(input logic [1:0] tsel, input logic bus);
        logic [4:0] e;
        e = 5'd0;
        case (tsel)
            2'b01: e = bus ? 5'(`WWDT_BUS_EXP1) : 5'(`WWDT_SLOW_EXP1);
            2'b10: e = bus ? 5'(`WWDT_BUS_EXP2) : 5'(`WWDT_SLOW_EXP2);
            2'b11: e = bus ? 5'(`WWDT_BUS_EXP3) : 5'(`WWDT_SLOW_EXP3);
            default: e = 5'd0;
        endcase
        return 19'(1) << e;
    endfunction

    // true when a word index selects the given register
    // shared by the write decoders so that all compare the same bits
    function automatic logic wwdt_hit(input logic [12:0] idx, input logic [12:0] reg_idx);
        return idx == reg_idx;
    endfunction

    // window opening count, bus clock only
    function automatic logic [18:0] wwdt_open(input logic [1:0] tsel);
        case (tsel)
            2'b01: return 19'(`WWDT_WIN_OPEN1);
            2'b10: return 19'(`WWDT_WIN_OPEN2);
            2'b11: return 19'(`WWDT_WIN_OPEN3);
            default: return 19'd0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // bus address phase capture

    logic wr_pend_q;
    logic [12:0] addr_q;
    logic [7:0] opt1_q;
    logic [7:0] opt2_q;
    logic opt1_locked_q;
    logic opt2_locked_q;
    logic cause_wdog_q;
    wwdt_svc_t svc_q;
    logic [18:0] cnt_q;
    logic [$clog2(SLOW_DIV+1)-1:0] div_q;
    logic [4:0] pulse_q;
    logic wdog_fire;
    wwdt_cfg_t cfg;
    logic tick;
    logic [7:0] wbyte;
    logic wr_cause;
    logic good_pair;

    assign cfg.tsel = opt1_q[`WWDT_OPT1_TSEL_HI:`WWDT_OPT1_TSEL_LO];
    assign cfg.clk_bus = opt2_q[`WWDT_OPT2_CLKSEL_BIT];
    assign cfg.window = opt2_q[`WWDT_OPT2_WIN_BIT];
    assign wbyte = hwdata[7:0];

    // latch writes, and build the read word for reads
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_pend_q <= 1'b0;
            addr_q <= 13'h0000;
            hrdata <= 32'h0000_0000;
        end else begin
            // one-cycle write strobe for the data phase that follows
            wr_pend_q <= 1'b0;
            if (hsel && hready && htrans[1]) begin
                wr_pend_q <= hwrite;
                // word index: byte address bits above the byte lanes
                addr_q <= haddr[14:2];
                hrdata <= 32'h0000_0000;
                if (!hwrite) begin
                    // read word is built now and stands through the data phase
                    case (haddr[14:2])
                        `WWDT_ADDR_CAUSE:
                            hrdata <= {26'd0, cause_wdog_q, 5'd0};
                        `WWDT_ADDR_OPT1:
                            hrdata <= {24'd0, opt1_q};
                        `WWDT_ADDR_OPT2:
                            hrdata <= {24'd0, opt2_q};
                        default: hrdata <= 32'h0000_0000;
                    endcase
                end
            end
        end
    end

    // zero wait state, always okay
    always_ff @(posedge clk) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers, write once except the low bits of options two

    always_ff @(posedge clk) begin
        if (rst) begin
            opt1_q <= `WWDT_OPT1_RESET; // R7
            opt1_locked_q <= 1'b0;
        end else if (wr_pend_q && !opt1_locked_q && wwdt_hit(addr_q, `WWDT_ADDR_OPT1)) begin
            // only the first write after rst counts; later ones are dropped
            opt1_q <= {wbyte[7:3], 3'b000};
            opt1_locked_q <= 1'b1; // R11
        end
    end

    // select bits lock; low bits stay writable
    always_ff @(posedge clk) begin
        if (rst) begin
            opt2_q <= `WWDT_OPT2_RESET; // R7
            opt2_locked_q <= 1'b0;
        end else if (wr_pend_q && wwdt_hit(addr_q, `WWDT_ADDR_OPT2)) begin
            // unimplemented bits read back as zero
            opt2_q[4:0] <= {wbyte[4], 1'b0, wbyte[2:0]};
            if (!opt2_locked_q) begin
                opt2_q[7:6] <= wbyte[7:6]; // R11
                opt2_locked_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // service sequence and counter

    // a write to the cause register is a service attempt
    assign wr_cause = wr_pend_q && wwdt_hit(addr_q, `WWDT_ADDR_CAUSE);
    // the second code completes the pair only when armed
    assign good_pair = wr_cause && svc_q == WWDT_SVC_ARMED && wbyte == `WWDT_KEY_SECOND;

    // 1 khz enable pulse
    always_ff @(posedge clk) begin
        if (rst || div_q == ($clog2(SLOW_DIV+1))'(SLOW_DIV - 1)) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end
    assign tick = cfg.clk_bus ? 1'b1 : (div_q == '0); // R6

    // pair tracking
    // a fault drops a half-done pair, as the system reset would
    always_ff @(posedge clk) begin
        if (rst) begin
            svc_q <= WWDT_SVC_IDLE;
        end else if (wdog_fire) begin
            svc_q <= WWDT_SVC_IDLE;
        end else if (wr_cause) begin
            case (svc_q)
                WWDT_SVC_IDLE: svc_q <= (wbyte == `WWDT_KEY_FIRST) ? WWDT_SVC_ARMED : WWDT_SVC_IDLE;
                WWDT_SVC_ARMED: svc_q <= (wbyte == `WWDT_KEY_FIRST) ? WWDT_SVC_ARMED : WWDT_SVC_IDLE; // R1
                default: svc_q <= WWDT_SVC_IDLE;
            endcase
        end
    end

    // timeout counter
    always_ff @(posedge clk) begin
        if (rst || cfg.tsel == 2'b00) begin
            cnt_q <= 19'd0; // R8
        end else if (good_pair) begin
            cnt_q <= 19'd0; // R13
        end else if (wdog_fire) begin
            // restart after a fault so the request does not repeat each tick
            cnt_q <= 19'd0;
        end else if (tick) begin
            // counts ticks of the selected source
            cnt_q <= cnt_q + 19'd1;
        end
    end

    // fault detection
    // three causes: timeout, bad code, early service in window mode
    // all of them are ignored while the watchdog is disabled
    always_comb begin
        wdog_fire = 1'b0;
        if (cfg.tsel != 2'b00) begin
            if (tick && cnt_q + 19'd1 >= wwdt_limit(cfg.tsel, cfg.clk_bus) && !good_pair) begin
                wdog_fire = 1'b1; // R3 R9 R10
            end
            if (wr_cause && wbyte != `WWDT_KEY_FIRST && wbyte != `WWDT_KEY_SECOND) begin
                wdog_fire = 1'b1; // R2
            end
            if (wr_cause && cfg.window && cfg.clk_bus && cnt_q < wwdt_open(cfg.tsel)) begin
                wdog_fire = 1'b1; // R4 R5
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // system reset pulse and cause flag

    // fixed-length request; a new fault restarts the length
    always_ff @(posedge clk) begin
        if (rst) begin
            pulse_q <= 5'd0;
            sys_reset_req <= 1'b0;
        end else if (wdog_fire) begin
            pulse_q <= 5'(`WWDT_RESET_PULSE);
            sys_reset_req <= 1'b1;
        end else if (pulse_q != 5'd0) begin
            pulse_q <= pulse_q - 5'd1;
            sys_reset_req <= pulse_q != 5'd1;
        end
    end

    // flag survives the system reset, cleared only by rst
    always_ff @(posedge clk) begin
        if (rst) begin
            cause_wdog_q <= 1'b0;
        end else if (wdog_fire) begin
            cause_wdog_q <= 1'b1; // R14
        end
    end

endmodule

`default_nettype wire

// File: design/wwdt_defines.svh
// register map, field positions, reset values and timing counts of the watchdog
// assumes a 50 MHz bus clock and an AHB-Lite word-per-register map
`ifndef WWDT_DEFINES_SVH
`define WWDT_DEFINES_SVH

// register indices; the byte address is the index times four
`define WWDT_ADDR_CAUSE 13'h1800
`define WWDT_ADDR_OPT1 13'h1802
`define WWDT_ADDR_OPT2 13'h1803
// register index to byte address
`define WWDT_IDX_SHIFT 2
// service codes
`define WWDT_KEY_FIRST 8'h55
`define WWDT_KEY_SECOND 8'hAA
// field positions
`define WWDT_CAUSE_WDOG_BIT 5
`define WWDT_OPT1_TSEL_HI 7
`define WWDT_OPT1_TSEL_LO 6
`define WWDT_OPT2_CLKSEL_BIT 7
`define WWDT_OPT2_WIN_BIT 6
// reset values
`define WWDT_OPT1_RESET 8'hC0
`define WWDT_OPT2_RESET 8'h00
// slow clock
`define WWDT_CLK_HZ 50000000
`define WWDT_SLOW_HZ 1000
// overflow exponents per timeout select
`define WWDT_SLOW_EXP1 5
`define WWDT_SLOW_EXP2 8
`define WWDT_SLOW_EXP3 10
`define WWDT_BUS_EXP1 13
`define WWDT_BUS_EXP2 16
`define WWDT_BUS_EXP3 18
// window opening counts, bus clock
`define WWDT_WIN_OPEN1 6144
`define WWDT_WIN_OPEN2 49152
`define WWDT_WIN_OPEN3 196608
// length of the system reset pulse in cycles
`define WWDT_RESET_PULSE 16

`endif

// File: design/wwdt_pkg.sv
// types shared by the watchdog design
// assumes wwdt_defines.svh for the numeric constants
package wwdt_pkg;

    // service sequence states
    typedef enum logic [1:0] {
        WWDT_SVC_IDLE = 2'b01,
        WWDT_SVC_ARMED = 2'b10
    } wwdt_svc_t;

    // decoded configuration
    typedef struct packed {
        logic [1:0] tsel;
        logic clk_bus;
        logic window;
    } wwdt_cfg_t;

endpackage

// File: tb/wwdt_top_monitor.sv
// port assertions for the watchdog, bound into wwdt_top
// assumes one clock and a synchronous active-high rst
`include "wwdt_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module wwdt_top_mon (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // reset request
    input wire logic sys_reset_req
);
    localparam logic [31:0] CA = 32'(`WWDT_ADDR_CAUSE) << `WWDT_IDX_SHIFT;
    logic acc;
    logic wr_q;
    logic fired_q;
    // accepted address phase
    assign acc = hsel && hready && htrans[1];
    // write data phase to the cause register
    always_ff @(posedge clk) begin
        wr_q <= !rst && acc && hwrite && haddr == CA;
    end
    // a reset request was seen since rst
    always_ff @(posedge clk) begin
        fired_q <= !rst && (fired_q || sys_reset_req);
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_bad_key;
        wr_q && hwdata[7:0] != `WWDT_KEY_FIRST && hwdata[7:0] != `WWDT_KEY_SECOND;
    endsequence
    sequence s_held;
        sys_reset_req [*8];
    endsequence
    a_bad_key: assert property (s_bad_key |=> sys_reset_req)
        else $error("bad key ignored");
    a_pulse_held: assert property ($rose(sys_reset_req) |-> s_held)
        else $error("reset pulse short");
    a_quiet_start: assert property ($fell(rst) |-> !sys_reset_req [*2])
        else $error("request after rst");
    a_rst_clear: assert property (disable iff (1'b0) rst |=> !sys_reset_req && hrdata == 0)
        else $error("rst left outputs");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("wait or error");
    a_data_hold: assert property (!acc |=> $stable(hrdata))
        else $error("read data moved");
    a_unmapped_rd: assert property (acc && !hwrite && haddr == CA + 32'h10 |=> hrdata == 0)
        else $error("unmapped read not zero");
    a_flag_set: assert property (fired_q && acc && !hwrite && haddr == CA
        |=> hrdata[`WWDT_CAUSE_WDOG_BIT])
        else $error("flag not set");
endmodule
bind wwdt_top wwdt_top_mon u_mon (.*);
`default_nettype wire

// File: tb/windowed_watchdog_timer_bench.sv
// watchdog bench over ahb-lite
// assumes wwdt_top with a raised slow clock rate
`include "wwdt_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module windowed_watchdog_timer_bench;
    localparam logic [31:0] CA = 32'(`WWDT_ADDR_CAUSE) << `WWDT_IDX_SHIFT;
    localparam logic [31:0] O1 = 32'(`WWDT_ADDR_OPT1) << `WWDT_IDX_SHIFT;
    localparam logic [31:0] O2 = 32'(`WWDT_ADDR_OPT2) << `WWDT_IDX_SHIFT;
    localparam int SLOW = 12_500_000;
    localparam int TK = `WWDT_CLK_HZ / SLOW;
    localparam int BUS = 1 << `WWDT_BUS_EXP1;
    logic clk = 0, rst = 1, hsel = 1, hwrite = 0;
    logic [1:0] htrans = '0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd_d;
    logic hreadyout, hresp, sys_reset_req;
    int err_count = 0, total_checks = 0;
    wwdt_top #(.SLOW_HZ(SLOW)) DUT (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .sys_reset_req(sys_reset_req));
    // 50 MHz clock
    initial begin
        forever #10 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
        end
    endtask
    // one transfer, data taken at the end of the data phase
    task automatic xf(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd_d = hrdata;
    endtask
    task automatic rdc(input logic [31:0] a, input logic [31:0] e);
        xf(0, a, '0);
        chk(rd_d, e);
    endtask
    // no reset request for n cycles
    task automatic quiet(input int n);
        logic s;
        s = 0;
        repeat (n) begin
            @(posedge clk);
            s |= sys_reset_req;
        end
        chk(s, 0);
    endtask
    // reset request arrives after lo and before hi cycles
    task automatic fire(input int lo, input int hi);
        int i;
        i = 0;
        while (sys_reset_req !== 1'b1 && i < hi) begin
            @(posedge clk);
            i++;
        end
        chk(i >= lo && i < hi, 1);
    endtask
    task automatic rst_dut();
        @(posedge clk);
        rst <= 1;
        repeat (20) @(posedge clk);
        rst <= 0;
    endtask
    task automatic cfg_bus();
        xf(1, O1, 32'h0000_0040);
        xf(1, O2, 32'h0000_00C0);
    endtask
    task automatic svc();
        xf(1, CA, 32'(`WWDT_KEY_FIRST));
        xf(1, CA, 32'(`WWDT_KEY_SECOND));
    endtask
    task automatic results();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // hang guard
    initial begin
        #1_500_000;
        err_count++;
        results();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_dut();
        rdc(CA, 0);
        rdc(O1, `WWDT_OPT1_RESET);
        rdc(O2, `WWDT_OPT2_RESET);
        rdc(CA + 32'h10, 0);
        fire((TK << 10) - 100, (TK << 10) + 20);
        rdc(CA, 32'h0000_0020);
        rst_dut();
        quiet(3000);
        svc();
        quiet(3000);
        xf(1, CA, 32'h0000_0012);
        fire(0, 3);
        rst_dut();
        cfg_bus();
        xf(1, O1, '0);
        xf(1, O2, '0);
        rdc(O1, 32'h0000_0040);
        rdc(O2, 32'h0000_00C0);
        quiet(`WWDT_WIN_OPEN1 - 1200);
        xf(1, CA, 32'(`WWDT_KEY_FIRST));
        fire(0, 3);
        rst_dut();
        cfg_bus();
        quiet(`WWDT_WIN_OPEN1 + 100);
        svc();
        fire(BUS - 30, BUS + 20);
        rst_dut();
        xf(1, O1, 32'h0000_0040);
        fire(TK * 28, TK * 34);
        rst_dut();
        xf(1, O1, '0);
        quiet(5000);
        results();
    end
endmodule
`default_nettype wire
